// [design/plh_defs.svh]
// Purpose: constants of the palette table host port
// Assumes: included by the package and the host port module
// Notes: select codes are {reg_select_high, reg_select_low}
`ifndef PLH_DEFS_SVH
`define PLH_DEFS_SVH
`define PLH_SEL_IDX_WR 2'h0
`define PLH_SEL_BUF 2'h1
`define PLH_SEL_IDX_RD 2'h3
`define PLH_IDX_W 8
`define PLH_COMP_W 6
`define PLH_BUF_W 18
`define PLH_RED_LSB 12
`define PLH_GRN_LSB 6
`define PLH_BLU_LSB 0
`define PLH_IDX_RST 8'h00
`define PLH_IDX_STEP 8'h01
`define PLH_BUF_RST 18'h00000
`define PLH_DOUT_RST 8'h00
`define PLH_TOP_ZERO 2'h0
`define PLH_PINS_IDLE 12'hc00
`endif

// [design/plh_host_port.sv]
// Purpose: host register access to a colour palette table
// Assumes: strobes and data arrive asynchronously, 125 MHz system clock
// Notes: each strobe level must hold at least four clocks
//
// What this block does
// - One index register, reached at select codes 0,0 and 1,1.
// - Write at 0,0 loads the index for later table writes.
// - Write at 0,0 also clears the entry buffer and restarts at red.
// - Write at 1,1 loads the index for later table reads.
// - After write at 1,1, buffer loads from table, then index increments.
// - Read at 0,0 behaves exactly like read at 1,1.
// - Entry buffer is 18 bits, staging between host and table.
// - Buffer moves as three byte accesses; device tracks the next byte.
// - Buffer byte writes keep data bits 0 to 5 only.
// - Buffer byte reads drive the component on the low six bits.
// - Buffer byte reads drive the top two bits as zero.
// - Component order is red, green, blue for reads and writes.
// - After third write, buffer goes to table at index; index increments.
// - After third read, buffer reloads from table at index; index increments.
// - Select lines are captured at the falling edge of the active strobe.
// - Write data is latched at the rising edge of the write strobe.
`timescale 1ns/1ns
`include "plh_defs.svh"
module plh_host_port (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Host pins, asynchronous
  input wire plh_pkg::plh_pins_s pins_in,
  output logic [7:0] host_bus_out,
  output logic host_bus_oe_n_out,
  // Pixel lookup
  input wire logic [`PLH_IDX_W-1:0] pix_addr_in,
  output logic [`PLH_BUF_W-1:0] pix_color_out
);
  import plh_pkg::*;

  plh_pins_s pins_s;
  plh_bus_out_s bus_q, bus_d;
  logic rd_prev_q, rd_prev_d;
  logic wr_prev_q, wr_prev_d;
  logic rd_fall, rd_rise, wr_fall, wr_rise;
  logic [1:0] sel_live;
  logic [1:0] sel_q, sel_d;
  logic [`PLH_IDX_W-1:0] idx_q, idx_d;
  logic [`PLH_BUF_W-1:0] buf_q, buf_d;
  plh_comp_e ptr_q, ptr_d;
  logic [`PLH_IDX_W-1:0] idx_inc;
  logic [`PLH_COMP_W-1:0] comp_now;
  logic [`PLH_COMP_W-1:0] wbyte;
  logic ram_we;
  logic [`PLH_IDX_W-1:0] ram_raddr;
  logic [`PLH_BUF_W-1:0] ram_rdata;

  function automatic plh_comp_e next_comp(input plh_comp_e c);
    case (c)
      PLH_RED: next_comp = PLH_GREEN;
      PLH_GREEN: next_comp = PLH_BLUE;
      default: next_comp = PLH_RED;
    endcase
  endfunction

  // Strobes and data share one synchroniser so their lag is equal
  plh_sync #(
    .W($bits(plh_pins_s)),
    .RST_VAL(`PLH_PINS_IDLE)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(pins_in),
    .sync_out(pins_s)
  );

  plh_lut_ram #(
    .AW(`PLH_IDX_W),
    .DW(`PLH_BUF_W)
  ) u_ram (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .we_in(ram_we),
    .waddr_in(idx_q),
    .wdata_in(buf_d),
    .raddr_in(ram_raddr),
    .rdata_out(ram_rdata),
    .pix_addr_in(pix_addr_in),
    .pix_data_out(pix_color_out)
  );

  // Edge detection on the synchronised strobes
  always_comb begin
    rd_prev_d = pins_s.rd_n;
    wr_prev_d = pins_s.wr_n;
    rd_fall = rd_prev_q & ~pins_s.rd_n;
    rd_rise = ~rd_prev_q & pins_s.rd_n;
    wr_fall = wr_prev_q & ~pins_s.wr_n;
    wr_rise = ~wr_prev_q & pins_s.wr_n;
    sel_live = {pins_s.reg_select_high, pins_s.reg_select_low};
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rd_prev_q <= 1'b1;
      wr_prev_q <= 1'b1;
    end else begin
      rd_prev_q <= rd_prev_d;
      wr_prev_q <= wr_prev_d;
    end
  end

  // Register state and table access
  always_comb begin
    sel_d = sel_q;
    idx_d = idx_q;
    buf_d = buf_q;
    ptr_d = ptr_q;
    bus_d = bus_q;
    ram_we = 1'b0;
    ram_raddr = idx_q;
    idx_inc = idx_q + `PLH_IDX_STEP;
    wbyte = pins_s.host_bus[`PLH_COMP_W-1:0];
    case (ptr_q)
      PLH_RED: comp_now = buf_q[`PLH_RED_LSB +: `PLH_COMP_W];
      PLH_GREEN: comp_now = buf_q[`PLH_GRN_LSB +: `PLH_COMP_W];
      default: comp_now = buf_q[`PLH_BLU_LSB +: `PLH_COMP_W];
    endcase
    if (rd_fall || wr_fall) begin
      sel_d = sel_live;
    end
    if (rd_fall) begin
      bus_d.host_bus_oe_n = 1'b0;
      case (sel_live)
        `PLH_SEL_IDX_WR, `PLH_SEL_IDX_RD: bus_d.host_bus = idx_q;
        `PLH_SEL_BUF: bus_d.host_bus = {`PLH_TOP_ZERO, comp_now};
        default: bus_d.host_bus = `PLH_DOUT_RST;
      endcase
    end
    if (rd_rise) begin
      bus_d.host_bus_oe_n = 1'b1;
      if (sel_q == `PLH_SEL_BUF) begin
        ptr_d = next_comp(ptr_q);
        if (ptr_q == PLH_BLUE) begin
          buf_d = ram_rdata;
          idx_d = idx_inc;
        end
      end
    end
    if (wr_rise) begin
      case (sel_q)
        `PLH_SEL_IDX_WR: begin
          idx_d = pins_s.host_bus;
          buf_d = `PLH_BUF_RST;
          ptr_d = PLH_RED;
        end
        `PLH_SEL_IDX_RD: begin
          ram_raddr = pins_s.host_bus;
          buf_d = ram_rdata;
          idx_d = pins_s.host_bus + `PLH_IDX_STEP;
          ptr_d = PLH_RED;
        end
        `PLH_SEL_BUF: begin
          case (ptr_q)
            PLH_RED: buf_d[`PLH_RED_LSB +: `PLH_COMP_W] = wbyte;
            PLH_GREEN: buf_d[`PLH_GRN_LSB +: `PLH_COMP_W] = wbyte;
            default: buf_d[`PLH_BLU_LSB +: `PLH_COMP_W] = wbyte;
          endcase
          ptr_d = next_comp(ptr_q);
          if (ptr_q == PLH_BLUE) begin
            ram_we = 1'b1;
            idx_d = idx_inc;
          end
        end
        default: begin
          // Select 1,0 belongs to another register; writes are dropped here
          idx_d = idx_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sel_q <= `PLH_SEL_IDX_WR;
      idx_q <= `PLH_IDX_RST;
      buf_q <= `PLH_BUF_RST;
      ptr_q <= PLH_RED;
      bus_q <= {`PLH_DOUT_RST, 1'b1};
    end else begin
      sel_q <= sel_d;
      idx_q <= idx_d;
      buf_q <= buf_d;
      ptr_q <= ptr_d;
      bus_q <= bus_d;
    end
  end

  assign host_bus_out = bus_q.host_bus;
  assign host_bus_oe_n_out = bus_q.host_bus_oe_n;

  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_idx_wr_load;
    wr_rise && sel_q == `PLH_SEL_IDX_WR |=> idx_q == $past(pins_s.host_bus);
  endproperty
  a_idx_wr_load: assert property (p_idx_wr_load)
    else $error("index not loaded by write-mode index write");

  property p_idx_wr_restart;
    wr_rise && sel_q == `PLH_SEL_IDX_WR |=> ptr_q == PLH_RED && buf_q == `PLH_BUF_RST;
  endproperty
  a_idx_wr_restart: assert property (p_idx_wr_restart)
    else $error("buffer sequence not restarted by index write");

  property p_idx_rd_load;
    wr_rise && sel_q == `PLH_SEL_IDX_RD |=>
      idx_q == 8'($past(pins_s.host_bus) + `PLH_IDX_STEP) && ptr_q == PLH_RED;
  endproperty
  a_idx_rd_load: assert property (p_idx_rd_load)
    else $error("read-mode index write did not advance index");

  property p_idx_alias;
    rd_fall && (sel_live == `PLH_SEL_IDX_WR || sel_live == `PLH_SEL_IDX_RD) |=>
      host_bus_out == $past(idx_q) && !host_bus_oe_n_out;
  endproperty
  a_idx_alias: assert property (p_idx_alias)
    else $error("index read returned wrong value");

  property p_buf_wr_mask;
    wr_rise && sel_q == `PLH_SEL_BUF && ptr_q == PLH_RED |=>
      buf_q[`PLH_RED_LSB +: `PLH_COMP_W] == $past(pins_s.host_bus[5:0]) && ptr_q == PLH_GREEN;
  endproperty
  a_buf_wr_mask: assert property (p_buf_wr_mask)
    else $error("red byte write stored wrong bits");

  property p_buf_rd_low;
    rd_fall && sel_live == `PLH_SEL_BUF && ptr_q == PLH_GREEN |=>
      host_bus_out[5:0] == $past(buf_q[`PLH_GRN_LSB +: `PLH_COMP_W]);
  endproperty
  a_buf_rd_low: assert property (p_buf_rd_low)
    else $error("green byte read returned wrong bits");

  property p_rd_top_zero;
    rd_fall && sel_live == `PLH_SEL_BUF |=> host_bus_out[7:6] == `PLH_TOP_ZERO;
  endproperty
  a_rd_top_zero: assert property (p_rd_top_zero)
    else $error("buffer read drove upper bits");

  property p_third_write;
    wr_rise && sel_q == `PLH_SEL_BUF && ptr_q == PLH_BLUE |->
      ram_we ##1 (idx_q == 8'($past(idx_q) + `PLH_IDX_STEP) && ptr_q == PLH_RED);
  endproperty
  a_third_write: assert property (p_third_write)
    else $error("third buffer write did not commit");

  property p_third_read;
    rd_rise && sel_q == `PLH_SEL_BUF && ptr_q == PLH_BLUE |=>
      idx_q == 8'($past(idx_q) + `PLH_IDX_STEP) && host_bus_oe_n_out;
  endproperty
  a_third_read: assert property (p_third_read)
    else $error("third buffer read did not reload");

  property p_sel_capture;
    (rd_fall || wr_fall) |=> sel_q == $past(sel_live);
  endproperty
  a_sel_capture: assert property (p_sel_capture)
    else $error("select not captured at strobe fall");

  property p_no_change_idle;
    !(rd_rise || wr_rise) |=> idx_q == $past(idx_q) && ptr_q == $past(ptr_q);
  endproperty
  a_no_change_idle: assert property (p_no_change_idle)
    else $error("state moved without a strobe");

  c_third_write: cover property (wr_rise && sel_q == `PLH_SEL_BUF && ptr_q == PLH_BLUE);
  c_third_read: cover property (rd_rise && sel_q == `PLH_SEL_BUF && ptr_q == PLH_BLUE);
  c_idx_rd: cover property (wr_rise && sel_q == `PLH_SEL_IDX_RD);
  c_wrap: cover property (idx_q == 8'hff ##1 idx_q == `PLH_IDX_RST);
endmodule

// [design/plh_lut_ram.sv]
// Purpose: colour look-up table storage
// Assumes: host port reads asynchronously, pixel port one cycle late
// Notes: contents are not reset, as in a real table
`timescale 1ns/1ns
module plh_lut_ram #(
  parameter int AW = 8,
  parameter int DW = 18
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Host port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out,
  // Pixel lookup port
  input wire logic [AW-1:0] pix_addr_in,
  output logic [DW-1:0] pix_data_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] pix_q, pix_d;

  always_comb begin
    pix_d = mem[pix_addr_in];
  end

  always_ff @(posedge sys_clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    if (sys_rst_in) begin
      pix_q <= '0;
    end else begin
      pix_q <= pix_d;
    end
  end

  assign rdata_out = mem[raddr_in];
  assign pix_data_out = pix_q;
endmodule

// [design/plh_pkg.sv]
// Purpose: types shared by the palette table host port modules
// Assumes: plh_defs.svh gives the widths
// Notes: pin struct order is fixed by the synchroniser idle value
`include "plh_defs.svh"
package plh_pkg;
  typedef enum logic [1:0] {
    PLH_RED = 2'b00,
    PLH_GREEN = 2'b01,
    PLH_BLUE = 2'b10
  } plh_comp_e;

  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic reg_select_high;
    logic reg_select_low;
    logic [7:0] host_bus;
  } plh_pins_s;

  typedef struct packed {
    logic [7:0] host_bus;
    logic host_bus_oe_n;
  } plh_bus_out_s;
endpackage

// [design/plh_sync.sv]
// Purpose: two-flop synchroniser for the asynchronous host pins
// Assumes: each bit is a level; no bus skew coherence is promised
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
module plh_sync #(
  parameter int W = 12,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Pins and synchronised copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q, meta_d;
  logic [W-1:0] sync_q, sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// [test/palette_lut_host_access_tb.sv]
// Purpose: self-checking bench of the palette table host port
// Assumes: host model accesses in red, green, blue triples, except one lone red write before an index restart
// Notes: rows run in order; each row relies on the state left by the last
`timescale 1ns/1ns
module palette_lut_host_access_tb;
  import plh_pkg::*;

  typedef struct packed {
    logic rd;
    logic [1:0] sel;
    logic [7:0] d;
    logic [7:0] exp;
  } plh_row_s;

  localparam plh_row_s ROWS [36] = '{
    '{1'b0, 2'h0, 8'h30, 8'h00}, '{1'b0, 2'h1, 8'hc1, 8'h00}, '{1'b0, 2'h1, 8'h02, 8'h00},
    '{1'b0, 2'h1, 8'h03, 8'h00}, '{1'b0, 2'h1, 8'h04, 8'h00}, '{1'b0, 2'h1, 8'h05, 8'h00},
    '{1'b0, 2'h1, 8'h06, 8'h00}, '{1'b1, 2'h0, 8'h00, 8'h32}, '{1'b1, 2'h3, 8'h00, 8'h32},
    '{1'b0, 2'h3, 8'h30, 8'h00}, '{1'b1, 2'h1, 8'h00, 8'h01}, '{1'b1, 2'h1, 8'h00, 8'h02},
    '{1'b1, 2'h1, 8'h00, 8'h03}, '{1'b1, 2'h1, 8'h00, 8'h04}, '{1'b1, 2'h1, 8'h00, 8'h05},
    '{1'b1, 2'h1, 8'h00, 8'h06}, '{1'b1, 2'h0, 8'h00, 8'h33}, '{1'b0, 2'h0, 8'hff, 8'h00},
    '{1'b0, 2'h1, 8'h3f, 8'h00}, '{1'b0, 2'h1, 8'h3f, 8'h00}, '{1'b0, 2'h1, 8'h3f, 8'h00},
    '{1'b1, 2'h3, 8'h00, 8'h00}, '{1'b0, 2'h2, 8'h55, 8'h00}, '{1'b1, 2'h2, 8'h00, 8'h00},
    '{1'b1, 2'h0, 8'h00, 8'h00}, '{1'b0, 2'h0, 8'h40, 8'h00}, '{1'b0, 2'h1, 8'h07, 8'h00},
    '{1'b0, 2'h0, 8'h40, 8'h00}, '{1'b0, 2'h1, 8'h08, 8'h00}, '{1'b0, 2'h1, 8'h09, 8'h00},
    '{1'b0, 2'h1, 8'h0a, 8'h00}, '{1'b0, 2'h3, 8'h40, 8'h00}, '{1'b1, 2'h1, 8'h00, 8'h08},
    '{1'b1, 2'h1, 8'h00, 8'h09}, '{1'b1, 2'h1, 8'h00, 8'h0a}, '{1'b1, 2'h0, 8'h00, 8'h42}
  };

  logic sys_clk_in;
  logic sys_rst_in;
  plh_pins_s pins;
  logic [7:0] host_bus;
  logic oe_n;
  logic [7:0] pix_addr;
  logic [17:0] pix_color;
  logic [7:0] q;
  logic oe;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  plh_host_port DUT (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in(pins),
    .host_bus_out(host_bus),
    .host_bus_oe_n_out(oe_n),
    .pix_addr_in(pix_addr),
    .pix_color_out(pix_color)
  );

  plh_host_model u_host (
    .sys_clk_in(sys_clk_in),
    .pins_out(pins),
    .host_bus_in(host_bus),
    .host_bus_oe_n_in(oe_n)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic idle_check;
    check({10'h000, host_bus}, 18'h00000);
    check({17'h00000, oe_n}, 18'h00001);
    check(pix_color, 18'h00000);
  endtask

  // Generous ceiling: about 17 clocks per access
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    sys_rst_in = 1'b1;
    pix_addr = 8'h00;
    repeat (20) @(negedge sys_clk_in);
    idle_check();
    sys_rst_in = 1'b0;
    foreach (ROWS[i]) begin
      u_host.access(ROWS[i].rd, ROWS[i].sel, ROWS[i].d, q, oe);
      if (ROWS[i].rd) begin
        check({10'h000, q}, {10'h000, ROWS[i].exp});
        check({17'h00000, oe}, 18'h00000);
      end
      check({17'h00000, oe_n}, 18'h00001);
    end
    // Table contents seen through the pixel port
    pix_addr = 8'h30;
    repeat (2) @(negedge sys_clk_in);
    check(pix_color, {6'h01, 6'h02, 6'h03});
    pix_addr = 8'hff;
    repeat (2) @(negedge sys_clk_in);
    check(pix_color, {6'h3f, 6'h3f, 6'h3f});
    // Second reset in mid-run clears the index
    sys_rst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    idle_check();
    sys_rst_in = 1'b0;
    u_host.access(1'b1, 2'h3, 8'h00, q, oe);
    check({10'h000, q}, 18'h00000);
    tally_and_finish();
  end
endmodule

// [test/plh_host_model.sv]
// Purpose: microprocessor model driving the palette table host pins
// Assumes: one access at a time, driven on falling clock edges
// Notes: slow strobes on purpose; the port oversamples asynchronous pins
`timescale 1ns/1ns
module plh_host_model (
  // Clock
  input wire logic sys_clk_in,
  // Host pins and read-back
  output plh_pkg::plh_pins_s pins_out,
  input wire logic [7:0] host_bus_in,
  input wire logic host_bus_oe_n_in
);
  import plh_pkg::*;

  initial begin
    pins_out = {1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
  end

  // One byte access; select and data stand three clocks before the strobe falls and four after it rises
  task automatic access(input logic rd, input logic [1:0] sel, input logic [7:0] d,
                        output logic [7:0] q, output logic oe_n);
    @(negedge sys_clk_in);
    pins_out.reg_select_high = sel[1];
    pins_out.reg_select_low = sel[0];
    pins_out.host_bus = d;
    repeat (3) @(negedge sys_clk_in);
    // Only one strobe low at a time
    if (rd) begin
      pins_out.rd_n = 1'b0;
    end else begin
      pins_out.wr_n = 1'b0;
    end
    repeat (6) @(negedge sys_clk_in);
    q = host_bus_in;
    oe_n = host_bus_oe_n_in;
    pins_out.rd_n = 1'b1;
    pins_out.wr_n = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    // Released lines float: show the inverse so a stale value cannot pass
    pins_out.host_bus = ~d;
    pins_out.reg_select_high = ~sel[1];
    pins_out.reg_select_low = ~sel[0];
    repeat (3) @(negedge sys_clk_in);
  endtask
endmodule
